// ==== core/qaicc_period_timer.sv ====
// conversion period timer: one-cycle tick every period cycles
`timescale 1ns/100ps
`default_nettype none
module qaicc_period_timer
    import qaicc_pkg::*;
#(
    parameter int unsigned W = 16
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic restart,
    input wire logic [W-1:0] period,
    output logic tick
);
    qaicc_timer_t r;
    qaicc_timer_t next_r;

    always_comb
    begin
        next_r = r;
        if (restart || r.count >= 16'(period - W'(1)))
        begin
            next_r.count = 16'h0000;
        end
        else
        begin
            next_r.count = r.count + 16'h0001;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign tick = !restart && (r.count >= 16'(period - W'(1)));

    // [RULE2] tick spacing matches the period
    logic [W-1:0] gap;
    logic gap_seen;
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gap <= '0;
            gap_seen <= 1'b0;
        end
        else if (tick || restart)
        begin
            gap <= '0;
            gap_seen <= tick;
        end
        else
        begin
            gap <= gap + W'(1);
        end
    end

    AST_PERIOD: assert property (@(posedge clock) // [RULE2]
        disable iff (sys_rst) (tick && gap_seen && $stable(period)) |->
            gap == W'(period - W'(1)))
        else $error("conversion period does not match channel count");
endmodule
`default_nettype wire

// ==== core/qaicc_pkg.sv ====
// shared constants and types of the quad analog input conversion control
package qaicc_pkg;

    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned PERIOD_BASE_US = 20;
    localparam int unsigned PERIOD_STEP_US = 5;
    localparam logic [15:0] PERIOD_BASE_CYC = 16'(PERIOD_BASE_US * CLK_MHZ);
    localparam logic [15:0] PERIOD_STEP_CYC = 16'(PERIOD_STEP_US * CLK_MHZ);

    localparam logic [15:0] IO_AREA_BASE = 16'h07D0;
    localparam logic [15:0] IO_UNIT_STRIDE = 16'h000A;
    localparam logic [15:0] SET_AREA_BASE = 16'h4E20;
    localparam logic [15:0] SET_UNIT_STRIDE = 16'h0064;

    localparam logic [15:0] OFS_RESULT1 = 16'h0001;
    localparam logic [15:0] OFS_RESULT4 = 16'h0004;
    localparam logic [15:0] OFS_STATUS = 16'h0009;

    localparam logic [15:0] SET_OFS_COUNT = 16'h0000;
    localparam logic [15:0] SET_OFS_MODE = 16'h0001;
    localparam logic [15:0] SET_OFS_RANGE1 = 16'h0002;
    localparam logic [15:0] SET_OFS_RANGE_STEP = 16'h0004;
    localparam logic [2:0] LOAD_LAST = 3'h5;

    localparam int unsigned ST_BIT_RANGE_ERR = 9;
    localparam int unsigned ST_BIT_MODE_ERR = 12;
    localparam int unsigned ST_BIT_DIRECT = 13;

    localparam logic [15:0] COUNT_MIN = 16'h0001;
    localparam logic [15:0] COUNT_MAX = 16'h0004;
    localparam logic [7:0] MODE_CYCLIC = 8'h00;
    localparam logic [7:0] MODE_DIRECT = 8'h01;

    typedef enum logic [2:0] {
        RANGE_BIP10 = 3'h0,
        RANGE_UNI10 = 3'h1,
        RANGE_MA4_20 = 3'h2,
        RANGE_BIP5 = 3'h3,
        RANGE_V1_5 = 3'h4
    } qaicc_range_t;
    localparam logic [15:0] RANGE_MAX = 16'h0004;

    typedef enum logic [2:0] {
        S_LOAD = 3'b001,
        S_IDLE = 3'b010,
        S_WAIT = 3'b100
    } qaicc_fsm_t;

    typedef struct packed {
        logic restart;
        logic program_mode;
        logic refresh;
        logic direct_convert_command;
    } qaicc_host_t;

    typedef struct packed {
        logic start;
        logic [1:0] channel;
        logic [2:0] range;
    } qaicc_adc_req_t;

    typedef struct packed {
        logic [15:0] count;
    } qaicc_timer_t;

    typedef struct packed {
        qaicc_fsm_t state;
        logic [2:0] load_idx;
        logic [2:0] ch_count;
        logic [3:0][2:0] ranges;
        logic mode_direct;
        logic err_mode;
        logic err_range;
        logic [1:0] chan;
        logic direct_run;
        logic cmd_pending;
        logic [3:0][15:0] samples;
        logic [3:0] svalid;
        logic [3:0][15:0] result;
        logic [15:0] rd_data;
        logic adc_start;
        logic timer_restart;
    } qaicc_core_t;

endpackage

// ==== core/qaicc_top.sv ====
// quad analog input conversion control: settings load, sweeps, io words
//
// Notes on behaviour
// [RULE1] only channels up to the configured count are converted
// [RULE2] cyclic period is 20, 25, 30 or 35 us for 1 to 4 channels
// [RULE3] result words of channels beyond the count read as zero
// [RULE4] each channel picks one of five input ranges on its own
// [RULE5] range settings come from setting words m+2, m+6, m+10, m+14
// [RULE6] settings load only at power-up or restart; host restarts after edits
// [RULE7] results are 16-bit words at io words n+1 to n+4 in order
// [RULE8] io base n is 2000 plus ten times the unit number
// [RULE9] mode is bits 7:0 of setting word m+1, common to all channels
// [RULE10] cyclic: convert once per period, publish at host io refresh
// [RULE11] cyclic conversion is the default mode
// [RULE12] direct: results change only on a direct conversion command
// [RULE13] in program mode conversion runs cyclic even if direct configured
// [RULE14] status bit 13 shows direct mode in operation
// [RULE15] status bit 12 shows an invalid mode setting
// [RULE16] status bit 9 shows an invalid range or channel count
// [RULE17] setting fields decode exactly by the chosen encodings
// [RULE18] result stays zero until its first conversion after a load
`timescale 1ns/100ps
`default_nettype none
module qaicc_top
    import qaicc_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [3:0] unit_number,
    input wire qaicc_host_t host,
    output logic [15:0] set_rd_addr,
    input wire logic [15:0] set_rd_data,
    input wire logic io_rd_en,
    input wire logic [15:0] io_addr,
    output logic [15:0] io_rd_data,
    output qaicc_adc_req_t adc_req,
    input wire logic adc_done,
    input wire logic [15:0] adc_data
);
    qaicc_core_t r;
    qaicc_core_t next_r;
    logic tick;
    logic cyclic_active;
    logic direct_active;
    logic [15:0] period_cycles;
    logic [15:0] n_base;
    logic [15:0] m_base;
    logic [15:0] io_rel;
    logic [15:0] status_word;

    // [RULE5] setting word offsets
    function automatic logic [15:0] load_offset(input logic [2:0] idx);
        if (idx == 3'h0)
            return SET_OFS_COUNT;
        else if (idx == 3'h1)
            return SET_OFS_MODE;
        else
            return 16'(SET_OFS_RANGE1 + SET_OFS_RANGE_STEP * (idx - 3'h2));
    endfunction

    // [RULE8] io word base
    assign n_base = 16'(IO_AREA_BASE + IO_UNIT_STRIDE * unit_number);
    assign m_base = 16'(SET_AREA_BASE + SET_UNIT_STRIDE * unit_number);
    assign io_rel = 16'(io_addr - n_base);
    assign set_rd_addr = 16'(m_base + load_offset(r.load_idx));

    // [RULE13] program mode forces cyclic
    assign cyclic_active = !r.mode_direct || host.program_mode;
    assign direct_active = r.mode_direct && !host.program_mode;

    // [RULE2] period grows by one step per channel
    assign period_cycles = (r.ch_count == 3'h0) ? PERIOD_BASE_CYC
        : 16'(PERIOD_BASE_CYC + PERIOD_STEP_CYC * (r.ch_count - 3'h1));

    always_comb
    begin
        status_word = 16'h0000;
        // [RULE14] direct mode flag
        status_word[ST_BIT_DIRECT] = direct_active;
        // [RULE15] mode setting error
        status_word[ST_BIT_MODE_ERR] = r.err_mode;
        // [RULE16] range or count error
        status_word[ST_BIT_RANGE_ERR] = r.err_range;
    end

    qaicc_period_timer #(
        .W(16)
    ) u_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .restart(r.timer_restart),
        .period(period_cycles),
        .tick(tick)
    );

    always_comb
    begin
        next_r = r;
        next_r.adc_start = 1'b0;
        next_r.timer_restart = 1'b0;
        if (host.direct_convert_command && r.state != S_IDLE)
            next_r.cmd_pending = 1'b1;
        // [RULE10] publish latest samples at io refresh
        if (cyclic_active && host.refresh && r.state != S_LOAD)
        begin
            for (int i = 0; i < 4; i++)
            begin
                // [RULE3] inactive channels read zero
                if (3'(i) < r.ch_count && r.svalid[i])
                    next_r.result[i] = r.samples[i];
                else
                    next_r.result[i] = 16'h0000;
            end
        end
        case (r.state)
            S_LOAD:
            begin
                // [RULE17] chosen encodings
                if (r.load_idx == 3'h0)
                begin
                    if (set_rd_data >= COUNT_MIN && set_rd_data <= COUNT_MAX)
                        next_r.ch_count = set_rd_data[2:0];
                    else
                    begin
                        next_r.ch_count = 3'h0;
                        next_r.err_range = 1'b1;
                    end
                end
                else if (r.load_idx == 3'h1)
                begin
                    // [RULE9] mode from low byte
                    // [RULE11] invalid mode falls back to cyclic
                    next_r.mode_direct = (set_rd_data[7:0] == MODE_DIRECT);
                    next_r.err_mode = (set_rd_data[7:0] != MODE_DIRECT)
                        && (set_rd_data[7:0] != MODE_CYCLIC);
                end
                else
                begin
                    // [RULE4] per-channel range
                    if (set_rd_data <= RANGE_MAX)
                        next_r.ranges[r.load_idx - 3'h2] = set_rd_data[2:0];
                    else
                    begin
                        next_r.ranges[r.load_idx - 3'h2] = RANGE_BIP10;
                        next_r.err_range = 1'b1;
                    end
                end
                if (r.load_idx == LOAD_LAST)
                begin
                    next_r.state = S_IDLE;
                    next_r.timer_restart = 1'b1;
                end
                else
                    next_r.load_idx = r.load_idx + 3'h1;
            end
            S_IDLE:
            begin
                // [RULE12] direct sweep only on command
                if (direct_active && r.ch_count != 3'h0
                    && (host.direct_convert_command || r.cmd_pending))
                begin
                    next_r.state = S_WAIT;
                    next_r.chan = 2'h0;
                    next_r.adc_start = 1'b1;
                    next_r.direct_run = 1'b1;
                    next_r.cmd_pending = 1'b0;
                end
                else if (cyclic_active && tick && r.ch_count != 3'h0)
                begin
                    next_r.state = S_WAIT;
                    next_r.chan = 2'h0;
                    next_r.adc_start = 1'b1;
                    next_r.direct_run = 1'b0;
                end
                else if (!direct_active)
                    next_r.cmd_pending = 1'b0;
            end
            S_WAIT:
            begin
                if (adc_done)
                begin
                    next_r.samples[r.chan] = adc_data;
                    next_r.svalid[r.chan] = 1'b1;
                    if (r.direct_run)
                        next_r.result[r.chan] = adc_data;
                    // [RULE1] stop after last active channel
                    if (3'(r.chan) + 3'h1 >= r.ch_count)
                        next_r.state = S_IDLE;
                    else
                    begin
                        next_r.chan = r.chan + 2'h1;
                        next_r.adc_start = 1'b1;
                    end
                end
            end
            default:
                next_r.state = S_LOAD;
        endcase
        // [RULE6] restart reloads settings
        if (host.restart)
        begin
            next_r.state = S_LOAD;
            next_r.load_idx = 3'h0;
            next_r.err_mode = 1'b0;
            next_r.err_range = 1'b0;
            next_r.cmd_pending = 1'b0;
            // [RULE18] results zero until reconverted
            next_r.svalid = 4'h0;
            next_r.result = '0;
            next_r.adc_start = 1'b0;
        end
        // [RULE7] io word read
        next_r.rd_data = 16'h0000;
        if (io_rd_en)
        begin
            if (io_rel >= OFS_RESULT1 && io_rel <= OFS_RESULT4)
                next_r.rd_data = r.result[2'(io_rel - OFS_RESULT1)];
            else if (io_rel == OFS_STATUS)
                next_r.rd_data = status_word;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r <= '0;
            r.state <= S_LOAD;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign io_rd_data = r.rd_data;
    assign adc_req.start = r.adc_start;
    assign adc_req.channel = r.chan;
    assign adc_req.range = r.ranges[r.chan];

    // checks
    AST_SKIP_INACTIVE: assert property (@(posedge clock) // [RULE1]
        disable iff (sys_rst) r.adc_start |-> 3'(r.chan) < r.ch_count)
        else $error("conversion started on an inactive channel");
    AST_ZERO_INACTIVE: assert property (@(posedge clock) // [RULE3]
        disable iff (sys_rst)
        (r.ch_count < 3'h4 && r.state == S_IDLE && !r.mode_direct)
            |-> r.result[3] == 16'h0000)
        else $error("inactive channel result not zero");
    AST_RANGE_OUT: assert property (@(posedge clock) // [RULE4]
        disable iff (sys_rst) adc_req.start |-> adc_req.range <= RANGE_MAX)
        else $error("converter given an undefined range code");
    AST_LOAD_ONLY: assert property (@(posedge clock) // [RULE6]
        disable iff (sys_rst)
        (r.state != S_LOAD && !host.restart) |=> $stable(r.ranges)
            && $stable(r.mode_direct) && $stable(r.ch_count))
        else $error("settings changed outside a load");
    AST_READ_RESULT: assert property (@(posedge clock) // [RULE7]
        disable iff (sys_rst) (io_rd_en && io_rel == OFS_RESULT1) |=>
            io_rd_data == $past(r.result[0]))
        else $error("io word n+1 does not return channel 1 result");
    AST_REFRESH: assert property (@(posedge clock) // [RULE10]
        disable iff (sys_rst)
        (cyclic_active && host.refresh && r.state == S_IDLE && !host.restart
            && r.svalid[0] && r.ch_count != 3'h0) |=>
            r.result[0] == $past(r.samples[0]))
        else $error("refresh did not publish channel 1 sample");
    AST_DIRECT_HOLD: assert property (@(posedge clock) // [RULE12]
        disable iff (sys_rst)
        (direct_active && !host.refresh && !host.restart && !adc_done)
            |=> $stable(r.result))
        else $error("direct mode results changed without a conversion");
    AST_STATUS_DIRECT: assert property (@(posedge clock) // [RULE14]
        disable iff (sys_rst) (io_rd_en && io_rel == OFS_STATUS) |=>
            io_rd_data[ST_BIT_DIRECT] == $past(direct_active))
        else $error("direct mode status bit wrong");
    AST_STATUS_MODE_ERR: assert property (@(posedge clock) // [RULE15]
        disable iff (sys_rst)
        (r.state == S_LOAD && r.load_idx == 3'h1 && !host.restart
            && set_rd_data[7:0] > MODE_DIRECT) |=> r.err_mode)
        else $error("invalid mode not flagged");
    AST_FRESH_ZERO: assert property (@(posedge clock) // [RULE18]
        disable iff (sys_rst)
        host.restart |=> r.result == '0 && r.svalid == 4'h0)
        else $error("results not cleared by a settings load");

    COV_CYCLIC_SWEEP: cover property (@(posedge clock) disable iff (sys_rst)
        tick && r.state == S_IDLE && r.ch_count == 3'h4);
    COV_DIRECT_CMD: cover property (@(posedge clock) disable iff (sys_rst)
        direct_active && host.direct_convert_command && r.state == S_IDLE);
    COV_PROGRAM_MODE: cover property (@(posedge clock) disable iff (sys_rst)
        r.mode_direct && host.program_mode && tick);
    COV_RESTART: cover property (@(posedge clock) disable iff (sys_rst)
        host.restart && r.state == S_WAIT);
endmodule
`default_nettype wire

// ==== dv/qaicc_far_model.sv ====
// model of the setting word area and the converter behind the block
`timescale 1ns/100ps
`default_nettype none
module qaicc_far_model
    import qaicc_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [3:0] unit_number,
    input wire logic [15:0] set_rd_addr,
    output logic [15:0] set_rd_data,
    input wire qaicc_adc_req_t adc_req,
    output logic adc_done,
    output logic [15:0] adc_data,
    input wire logic [15:0] cfg_count,
    input wire logic [15:0] cfg_mode,
    input wire logic [3:0][15:0] cfg_range,
    input wire logic [7:0] tag,
    input wire logic [7:0] delay
);
    logic [15:0] ofs;
    logic busy;
    logic [7:0] cnt;

    assign ofs = set_rd_addr - (16'h4E20 + 16'h0064 * {12'h000, unit_number});

    always_comb
    begin
        case (ofs)
            16'h0000: set_rd_data = cfg_count;
            16'h0001: set_rd_data = cfg_mode;
            16'h0002: set_rd_data = cfg_range[0];
            16'h0006: set_rd_data = cfg_range[1];
            16'h000A: set_rd_data = cfg_range[2];
            16'h000E: set_rd_data = cfg_range[3];
            // words outside the block never look like a valid setting
            default: set_rd_data = 16'hA5A5;
        endcase
    end

    // result carries tag, range and channel so each word can be traced
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy <= 1'b0;
            cnt <= 8'h00;
            adc_done <= 1'b0;
            adc_data <= 16'h0000;
        end
        else
        begin
            adc_done <= 1'b0;
            // data toggles outside done so a stale capture shows up
            adc_data <= ~adc_data;
            if (adc_req.start)
            begin
                busy <= 1'b1;
                cnt <= delay;
            end
            else if (busy && cnt == 8'h00)
            begin
                busy <= 1'b0;
                adc_done <= 1'b1;
                adc_data <= {tag, 1'b0, adc_req.range, 2'h0, adc_req.channel};
            end
            else if (busy)
            begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// testbench of the quad analog input conversion control
`timescale 1ns/100ps
`default_nettype none
module tb;
    import qaicc_pkg::*;

    // unit 3: io base 2030
    localparam logic [15:0] N_BASE = 16'h07EE;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] unit_number = 4'h3;
    qaicc_host_t host = '0;
    logic io_rd_en = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic [15:0] set_rd_addr, set_rd_data, io_rd_data, adc_data;
    qaicc_adc_req_t adc_req;
    logic adc_done;
    logic [15:0] cfg_count = 16'h0002;
    logic [15:0] cfg_mode = 16'h0000;
    logic [3:0][15:0] cfg_range = {16'h0001, 16'h0002, 16'h0003, 16'h0004};
    logic [7:0] tag = 8'h11;
    logic [7:0] delay = 8'h03;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    int n_start = 0;
    int n_start0 = 0;
    int t_start0 = 0;
    int n_sweep = 0;
    int last_ch = 1;

    always #5 clock = ~clock;

    qaicc_top DUT (.clock(clock), .sys_rst(sys_rst),
        .unit_number(unit_number), .host(host), .set_rd_addr(set_rd_addr),
        .set_rd_data(set_rd_data), .io_rd_en(io_rd_en), .io_addr(io_addr),
        .io_rd_data(io_rd_data), .adc_req(adc_req), .adc_done(adc_done),
        .adc_data(adc_data));

    qaicc_far_model far (.clock(clock), .sys_rst(sys_rst),
        .unit_number(unit_number), .set_rd_addr(set_rd_addr),
        .set_rd_data(set_rd_data), .adc_req(adc_req), .adc_done(adc_done),
        .adc_data(adc_data), .cfg_count(cfg_count), .cfg_mode(cfg_mode),
        .cfg_range(cfg_range), .tag(tag), .delay(delay));

    always @(posedge clock)
    begin
        cyc++;
        if (adc_req.start === 1'b1)
        begin
            n_start++;
            if (adc_req.channel === 2'h0)
            begin
                n_start0++;
                t_start0 = cyc;
            end
        end
        if (adc_done === 1'b1 && adc_req.channel === 2'(last_ch))
            n_sweep++;
    end

    task stop_test();
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input string name, input logic [15:0] exp,
        input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task rd_chk(input string name, input logic [15:0] ofs,
        input logic [15:0] exp);
        logic [15:0] d;
        @(posedge clock);
        io_rd_en <= 1'b1;
        io_addr <= N_BASE + ofs;
        @(posedge clock);
        io_rd_en <= 1'b0;
        #1 d = io_rd_data;
        chk(name, exp, d);
    endtask

    // which: 0 restart, 1 refresh, 2 direct conversion command
    task pulse(input int which);
        @(posedge clock);
        case (which)
            0: host.restart <= 1'b1;
            1: host.refresh <= 1'b1;
            default: host.direct_convert_command <= 1'b1;
        endcase
        @(posedge clock);
        host.restart <= 1'b0;
        host.refresh <= 1'b0;
        host.direct_convert_command <= 1'b0;
        if (which == 0)
            repeat (10) @(posedge clock);
    endtask

    task wait_ev(input bit sweep);
        int base;
        base = sweep ? n_sweep : n_start0;
        for (int i = 0; i < 8000 && base == (sweep ? n_sweep : n_start0); i++)
        begin
            @(posedge clock);
            #1;
        end
        if (base == (sweep ? n_sweep : n_start0))
        begin
            failures++;
            stop_test();
        end
    endtask

    function automatic logic [15:0] res(input logic [7:0] tg,
        input logic [2:0] rg, input logic [1:0] ch);
        return {tg, 1'b0, rg, 2'h0, ch};
    endfunction

    task no_starts();
        int s;
        s = n_start;
        // a window 500 cycles past the longest period
        repeat (4000) @(posedge clock);
        chk("idle starts", 16'h0000, 16'(n_start - s));
    endtask

    initial
    begin
        int t1;
        int s1;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        for (int a = 1; a <= 5; a++)
            rd_chk("word after load", 16'(a), 16'h0000); // zero
        rd_chk("status", 16'h0009, 16'h0000); // cyclic default
        wait_ev(1);
        rd_chk("before refresh", 16'h0001, 16'h0000); // held
        pulse(1);
        rd_chk("ch1", 16'h0001, res(8'h11, 3'h4, 2'h0)); // in order
        rd_chk("ch2", 16'h0002, res(8'h11, 3'h3, 2'h1)); // unit base
        rd_chk("ch3", 16'h0003, 16'h0000); // unused zero
        // settings edited without restart must not be taken
        tag <= 8'h22;
        cfg_count <= 16'h0004;
        wait_ev(1);
        rd_chk("old ch1", 16'h0001, res(8'h11, 3'h4, 2'h0)); // held
        pulse(1);
        rd_chk("new ch1", 16'h0001, res(8'h22, 3'h4, 2'h0)); // copy
        rd_chk("ch3 kept", 16'h0003, 16'h0000); // no reload
        for (int k = 1; k <= 4; k++)
        begin
            cfg_count <= 16'(k);
            delay <= 8'(3 + 10 * k);
            pulse(0); // host restarts
            last_ch = k - 1;
            wait_ev(0);
            t1 = t_start0;
            s1 = n_start;
            wait_ev(0);
            chk("period", 16'h07D0 + 16'h01F4 * 16'(k - 1),
                16'(t_start0 - t1)); // period
            chk("starts", 16'(k), 16'(n_start - s1)); // count
        end
        pulse(1);
        for (int c = 0; c < 4; c++)
            rd_chk("all", 16'(c + 1), res(8'h22, 3'(4 - c), 2'(c)));
        // upper byte lies outside the mode field and must be ignored
        cfg_mode <= 16'hFF01;
        tag <= 8'h33;
        pulse(0);
        rd_chk("status", 16'h0009, 16'h2000); // direct
        no_starts(); // no command no update
        rd_chk("direct ch1", 16'h0001, 16'h0000); // zero
        pulse(2); // host command
        wait_ev(1);
        for (int c = 0; c < 4; c++)
            rd_chk("direct", 16'(c + 1),
                res(8'h33, 3'(4 - c), 2'(c)));
        tag <= 8'h44;
        @(posedge clock);
        host.program_mode <= 1'b1;
        rd_chk("status", 16'h0009, 16'h0000); // cyclic flag
        wait_ev(1);
        pulse(1);
        rd_chk("prog ch4", 16'h0004, res(8'h44, 3'h1, 2'h3));
        @(posedge clock);
        host.program_mode <= 1'b0;
        cfg_mode <= 16'h0002;
        cfg_count <= 16'h0002;
        cfg_range[0] <= 16'h0000;
        cfg_range[1] <= 16'h0007;
        pulse(0);
        last_ch = 1;
        rd_chk("status", 16'h0009, 16'h1200); // bad
        wait_ev(1);
        pulse(1);
        rd_chk("bad ch1", 16'h0001, res(8'h44, 3'h0, 2'h0));
        rd_chk("bad ch2", 16'h0002, res(8'h44, 3'h0, 2'h1));
        cfg_mode <= 16'h0000;
        cfg_range[1] <= 16'h0003;
        cfg_count <= 16'h0000;
        pulse(0);
        rd_chk("status", 16'h0009, 16'h0200); // bad count
        no_starts(); // none converted
        stop_test();
    end
endmodule
`default_nettype wire
